//--- rtl/double_rate_sample_multiplexer.sv
// Double-rate sample interleaver and reassembler for an eight-channel link.
`timescale 1ns/1ps
// Operation
// - Double-rate mode doubles the internal sample clock.
// - Sample words stay 24 bits in double-rate.
// - Double-rate forces interleaving automatically.
// - Channel n uses link 2n-1 (a), 2n (b).
// - Link frames stay at base rate.
// - Base rate carries eight independent channels.
// - Double-rate carries four channels via interleaving.
module double_rate_sample_multiplexer (
  input  wire logic                          clk_in,          // 25 MHz system clock.
  input  wire logic                          rst_in,          // Asynchronous reset, active high.
  input  wire logic                          double_rate_mode_in, // Double-rate enable.
  input  wire logic                          base_48k_in,     // Base rate 48 kHz, else 44.1 kHz.
  output logic                               rate_mult_out,   // Internal clock is doubled.
  output logic                               interleave_out,  // Link uses interleaving.
  output logic [31:0]                        internal_hz_out, // Internal sample rate.
  output logic [31:0]                        link_hz_out,     // Link frame rate.
  input  wire logic [smux_pkg::SAMPLE_W-1:0] tx_data_in,      // Internal sample to send.
  input  wire logic [smux_pkg::LINK_IDX_W-1:0] tx_chan_in,    // Internal channel index.
  input  wire logic                          tx_valid_in,     // Sample offered.
  output logic                               tx_ready_out,    // Sample accepted.
  output logic [smux_pkg::SAMPLE_W-1:0]      link_tx_data_out,// Link slot word.
  output logic [smux_pkg::LINK_IDX_W-1:0]    link_tx_slot_out,// Link slot, 0 is channel 1.
  output logic                               link_tx_valid_out,// Slot word valid.
  input  wire logic                          link_tx_ready_in,// Link accepts slot.
  input  wire logic [smux_pkg::SAMPLE_W-1:0] link_rx_data_in, // Received slot word.
  input  wire logic [smux_pkg::LINK_IDX_W-1:0] link_rx_slot_in,// Received slot index.
  input  wire logic                          link_rx_valid_in,// Received word strobe.
  output logic [smux_pkg::SAMPLE_W-1:0]      rx_data_out,     // Reassembled sample.
  output logic [smux_pkg::LINK_IDX_W-1:0]    rx_chan_out,     // Internal channel index.
  output logic                               rx_valid_out     // Sample strobe.
);
  localparam int unsigned BW = smux_pkg::SAMPLE_W + smux_pkg::LINK_IDX_W;

  // Channel n (zero based) of a pair maps to slot 2n, plus one for the b sample.
  function automatic logic [smux_pkg::LINK_IDX_W-1:0] pair_slot(
    input logic [smux_pkg::DR_IDX_W-1:0] ch, input logic second);
    pair_slot = {ch, second};
  endfunction

  // Mode follows the enable directly; interleave cannot be chosen separately.
  assign rate_mult_out   = double_rate_mode_in;
  assign interleave_out  = double_rate_mode_in;
  wire [31:0] base_hz    = base_48k_in ? smux_pkg::BASE_48_HZ : smux_pkg::BASE_441_HZ;
  assign internal_hz_out = double_rate_mode_in ? base_hz * smux_pkg::RATE_MULT_DR : base_hz;
  assign link_hz_out     = base_hz;

  // Transmit: a/b phase per double-rate channel alternates each accepted sample.
  logic [smux_pkg::DR_CH-1:0] tx_phase_r;
  wire [smux_pkg::DR_IDX_W-1:0] tx_dch = tx_chan_in[smux_pkg::DR_IDX_W-1:0];
  wire tx_ch_ok  = !double_rate_mode_in || !tx_chan_in[smux_pkg::LINK_IDX_W-1];
  wire [smux_pkg::LINK_IDX_W-1:0] tx_slot =
    double_rate_mode_in ? pair_slot(tx_dch, tx_phase_r[tx_dch]) : tx_chan_in;
  wire buf_ready;
  wire tx_take = tx_valid_in && buf_ready && tx_ch_ok;
  // Out-of-range channels in double-rate are dropped so the stream never stalls.
  assign tx_ready_out = buf_ready || !tx_ch_ok;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_phase_r <= '0;
    end else if (!double_rate_mode_in) begin
      tx_phase_r <= '0;
    end else if (tx_take) begin
      tx_phase_r[tx_dch] <= ~tx_phase_r[tx_dch];
    end
  end

  skid_buffer #(.WIDTH(BW)) u_buf (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .s_data_in   ({tx_slot, tx_data_in}),
    .s_valid_in  (tx_valid_in && tx_ch_ok),
    .s_ready_out (buf_ready),
    .m_data_out  ({link_tx_slot_out, link_tx_data_out}),
    .m_valid_out (link_tx_valid_out),
    .m_ready_in  (link_tx_ready_in)
  );

  // Receive: emit the even-slot a sample at once, then hold and emit the odd-slot b sample.
  smux_pkg::rx_state_t rx_state_r;
  smux_pkg::rx_state_t rx_state_nxt;
  logic [smux_pkg::SAMPLE_W-1:0] rx_b_r;
  logic                          rx_b_pend_r;
  logic [smux_pkg::SAMPLE_W-1:0] rx_data_r;
  logic [smux_pkg::LINK_IDX_W-1:0] rx_chan_r;
  logic                          rx_valid_r;
  wire rx_is_b   = link_rx_slot_in[0];
  wire [smux_pkg::LINK_IDX_W-1:0] rx_dch =
    {1'b0, link_rx_slot_in[smux_pkg::LINK_IDX_W-1:1]};

  always_comb begin
    rx_state_nxt = rx_state_r;
    unique case (rx_state_r)
      smux_pkg::RX_IDLE: begin
        // An a word that lands while the previous b is still being emitted is refused.
        if (double_rate_mode_in && link_rx_valid_in && !rx_is_b && !rx_b_pend_r) begin
          rx_state_nxt = smux_pkg::RX_HAVE_A;
        end
      end
      smux_pkg::RX_HAVE_A: begin
        if (!double_rate_mode_in) rx_state_nxt = smux_pkg::RX_IDLE;
        else if (link_rx_valid_in && rx_is_b) rx_state_nxt = smux_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_state_r  <= smux_pkg::RX_IDLE;
      rx_data_r   <= smux_pkg::SAMPLE_RST;
      rx_chan_r   <= '0;
      rx_valid_r  <= 1'b0;
      rx_b_r      <= smux_pkg::SAMPLE_RST;
      rx_b_pend_r <= 1'b0;
    end else begin
      rx_state_r  <= rx_state_nxt;
      rx_valid_r  <= 1'b0;
      rx_b_pend_r <= 1'b0;
      if (!double_rate_mode_in) begin
        if (link_rx_valid_in) begin
          rx_data_r  <= link_rx_data_in;
          rx_chan_r  <= link_rx_slot_in;
          rx_valid_r <= 1'b1;
        end
      end else if (rx_b_pend_r) begin
        rx_data_r  <= rx_b_r;
        rx_valid_r <= 1'b1;
      end else if (link_rx_valid_in && (rx_state_r == smux_pkg::RX_IDLE) && !rx_is_b) begin
        rx_data_r  <= link_rx_data_in;
        rx_chan_r  <= rx_dch;
        rx_valid_r <= 1'b1;
      end
      if (double_rate_mode_in && link_rx_valid_in && rx_is_b &&
          rx_state_r == smux_pkg::RX_HAVE_A) begin
        rx_b_r      <= link_rx_data_in;
        rx_b_pend_r <= 1'b1;
      end
    end
  end

  assign rx_data_out  = rx_data_r;
  assign rx_chan_out  = rx_chan_r;
  assign rx_valid_out = rx_valid_r;

  AST_LINK_RATE: assert property (@(posedge clk_in) disable iff (rst_in)
    link_hz_out <= smux_pkg::MAX_LINK_HZ) else $error("link rate above base");
  AST_DR_RATE: assert property (@(posedge clk_in) disable iff (rst_in)
    double_rate_mode_in |-> internal_hz_out == 2 * link_hz_out) else $error("rate not doubled");
  AST_AUTO_IL: assert property (@(posedge clk_in) disable iff (rst_in)
    interleave_out == double_rate_mode_in) else $error("interleave not automatic");
  AST_PAIR_SLOT: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_take && double_rate_mode_in |-> tx_slot[2:1] == tx_dch) else $error("wrong slot pair");
  AST_SINGLE_SLOT: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_take && !double_rate_mode_in |-> tx_slot == tx_chan_in) else $error("slot changed");
  AST_FOUR_CH: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_take && double_rate_mode_in |-> !tx_chan_in[2]) else $error("channel above four");
  AST_WIDTH: assert property (@(posedge clk_in) disable iff (rst_in)
    !double_rate_mode_in && link_rx_valid_in |=>
      rx_valid_out && rx_data_out == $past(link_rx_data_in))
    else $error("sample word altered");
  sequence s_b_arrives;
    double_rate_mode_in && link_rx_valid_in && rx_is_b && rx_state_r == smux_pkg::RX_HAVE_A;
  endsequence
  AST_RX_ORDER: assert property (@(posedge clk_in) disable iff (rst_in)
    s_b_arrives ##0 double_rate_mode_in[*2] |->
      ##1 rx_valid_out && rx_data_out == $past(link_rx_data_in, 2))
    else $error("b sample not second");
endmodule

//--- inc/smux_pkg.sv
// Shared constants for the double-rate sample multiplexer.
package smux_pkg;
  localparam int unsigned SAMPLE_W      = 24;
  localparam int unsigned LINK_CH       = 8;
  localparam int unsigned DR_CH         = 4;
  localparam int unsigned LINK_IDX_W    = 3;
  localparam int unsigned DR_IDX_W      = 2;
  localparam int unsigned BASE_441_HZ   = 44100;
  localparam int unsigned BASE_48_HZ    = 48000;
  localparam int unsigned MAX_LINK_HZ   = 48000;
  localparam int unsigned RATE_MULT_DR  = 2;
  localparam int unsigned BUF_DEPTH     = 2;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 24'h000000;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_HAVE_A
  } rx_state_t;
endpackage

//--- rtl/skid_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module skid_buffer #(
  parameter int unsigned WIDTH = 27
) (
  input  wire logic             clk_in,    // System clock.
  input  wire logic             rst_in,    // Asynchronous reset, active high.
  input  wire logic [WIDTH-1:0] s_data_in, // Word from the source.
  input  wire logic             s_valid_in,// Source holds a word.
  output logic                  s_ready_out,// Buffer can accept.
  output logic [WIDTH-1:0]      m_data_out,// Word toward the sink.
  output logic                  m_valid_out,// Buffer holds a word.
  input  wire logic             m_ready_in // Sink accepts.
);
  logic [WIDTH-1:0] mem_r [smux_pkg::BUF_DEPTH];
  logic             wp_r;
  logic             rp_r;
  logic [1:0]       cnt_r;
  wire              push = s_valid_in && s_ready_out;
  wire              pop  = m_valid_out && m_ready_in;
  assign s_ready_out = (cnt_r != 2'h2);
  assign m_valid_out = (cnt_r != 2'h0);
  assign m_data_out  = mem_r[rp_r];
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) mem_r[wp_r] <= s_data_in;
  end
endmodule

//--- testbench/link_sink_model.sv
// Behavioural model of the far link device that accepts slot words.
`timescale 1ns/1ps
module link_sink_model (
  input  wire logic clk_in,    // System clock.
  input  wire logic stall_in,  // Holds acceptance off.
  input  wire logic rnd_in,    // Accepts only on random cycles.
  output logic      ready_out  // Slot word accepted.
);
  initial ready_out = 1'b0;
  // A real recorder may stall at any time, so acceptance is random when asked.
  always @(negedge clk_in) begin
    ready_out <= !stall_in && (!rnd_in || $urandom_range(0, 1) == 1);
  end
endmodule

//--- testbench/double_rate_sample_multiplexer_bench.sv
// Self-checking bench for the double-rate sample multiplexer.
`timescale 1ns/1ps
module double_rate_sample_multiplexer_bench;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        dr = 1'b0;
  logic        b48 = 1'b0;
  logic        txv = 1'b0;
  logic        lrv = 1'b0;
  logic        stall = 1'b0;
  logic        rnd = 1'b0;
  logic [23:0] txd = 24'h0;
  logic [23:0] lrd = 24'h0;
  logic [2:0]  txc = 3'h0;
  logic [2:0]  lrs = 3'h0;
  logic        rdy, lrdy, ltv, rxv, rm, il;
  logic [23:0] ltd, rxd;
  logic [2:0]  lts, rxc;
  logic [31:0] ihz, lhz;
  logic [26:0] exp_tx[$];
  logic [26:0] exp_rx[$];
  logic        ph[4];
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;

  initial forever #20 clk_in = ~clk_in;

  double_rate_sample_multiplexer uut (.clk_in(clk_in), .rst_in(rst_in),
    .double_rate_mode_in(dr), .base_48k_in(b48), .rate_mult_out(rm), .interleave_out(il),
    .internal_hz_out(ihz), .link_hz_out(lhz), .tx_data_in(txd), .tx_chan_in(txc),
    .tx_valid_in(txv), .tx_ready_out(rdy), .link_tx_data_out(ltd), .link_tx_slot_out(lts),
    .link_tx_valid_out(ltv), .link_tx_ready_in(lrdy), .link_rx_data_in(lrd),
    .link_rx_slot_in(lrs), .link_rx_valid_in(lrv), .rx_data_out(rxd), .rx_chan_out(rxc),
    .rx_valid_out(rxv));
  link_sink_model far (.clk_in(clk_in), .stall_in(stall), .rnd_in(rnd), .ready_out(lrdy));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Leaves the valid high so that calls run back to back; the caller drops it.
  task automatic send(input logic [2:0] ch);
    int n;
    n = 0;
    txc = ch;
    txd = 24'($urandom);
    txv = 1'b1;
    #1;
    while (rdy !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    if (dr && ch > 3) cmp(rdy, 1);
    else if (dr) begin
      exp_tx.push_back({ch[1:0], ph[ch[1:0]], txd});
      ph[ch[1:0]] = ~ph[ch[1:0]];
    end else exp_tx.push_back({ch, txd});
    @(negedge clk_in);
  endtask

  task automatic recv(input logic [2:0] s);
    lrs = s;
    lrd = 24'($urandom);
    lrv = 1'b1;
    exp_rx.push_back({dr ? {1'b0, s[2:1]} : s, lrd});
    @(negedge clk_in);
    lrv = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      close_out;
    end
  end

  // Outputs move on the rising edge and the sink's ready on the falling one, so both have
  // settled a little after the falling edge and hold until the edge that pops the word.
  always @(negedge clk_in) begin
    #2;
    if (ltv === 1'b1 && lrdy === 1'b1) begin
      if (exp_tx.size() == 0) cmp(1, 0);
      else cmp({lts, ltd}, exp_tx.pop_front());
    end
    if (rxv === 1'b1) begin
      if (exp_rx.size() == 0) cmp(1, 0);
      else cmp({rxc, rxd}, exp_rx.pop_front());
    end
  end

  initial begin
    void'($urandom(32'hcab7));
    ph = '{default: 1'b0};
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    cmp({rdy, ltv, rxv}, 3'b100);
    for (int i = 0; i < 4; i++) begin
      dr = i[1];
      b48 = i[0];
      #1;
      cmp(rm, dr);
      cmp(il, dr);
      cmp(ihz, (b48 ? smux_pkg::BASE_48_HZ : smux_pkg::BASE_441_HZ) * (dr ? 2 : 1));
      cmp(lhz, b48 ? smux_pkg::BASE_48_HZ : smux_pkg::BASE_441_HZ);
    end
    dr = 1'b0;
    rnd = 1'b1;
    @(negedge clk_in);
    for (int i = 0; i < 8; i++) send(3'(i));
    txv = 1'b0;
    for (int i = 0; i < 8; i++) recv(3'(i));
    while (ltv === 1'b1) @(negedge clk_in);
    stall = 1'b1;
    repeat (2) @(negedge clk_in);
    send(3'h3);
    send(3'h4);
    txv = 1'b0;
    cmp(rdy, 0);
    stall = 1'b0;
    dr = 1'b1;
    @(negedge clk_in);
    for (int r = 0; r < 2; r++) for (int i = 0; i < 5; i++) send(3'(i));
    send(3'h1);
    txv = 1'b0;
    for (int i = 0; i < 8; i++) recv(3'(i));
    // Leaving double rate must restart channel 1, left on its odd slot, on its even link slot.
    dr = 1'b0;
    ph = '{default: 1'b0};
    @(negedge clk_in);
    dr = 1'b1;
    send(3'h1);
    txv = 1'b0;
    for (int k = 0; k < 300 && (exp_tx.size() + exp_rx.size()) > 0; k++) @(negedge clk_in);
    cmp(exp_tx.size() + exp_rx.size(), 0);
    close_out;
  end
endmodule
